/* File: src/fbmc_ctrl.sv */
// host controller driving a parallel nor flash through its pins
`timescale 1ns/1ns
`include "fbmc_map.svh"
module fbmc_ctrl #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter int READY_CYC = `FBMC_READY_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // user request
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic boost_req,
  input wire logic flash_reset_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic aborted,
  output logic dev_busy,
  // flash pins
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n,
  output logic hw_reset_n,
  output logic program_boost_pin,
  output logic [ADDR_W-1:0] addr_pins,
  output logic [DATA_W-1:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [DATA_W-1:0] data_pins_i,
  input wire logic ready_busy_n
);
  localparam int CNT_W = 16;

  typedef struct packed {
    fbmc_pkg::fbmc_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] rb_sync;
    logic rb_q;
    logic [1:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_pin_n;
    logic boost;
    logic doe;
    logic rdy;
    logic rvalid;
    logic abort;
  } fbmc_s;

  fbmc_s cur_r;
  fbmc_s cur_nxt;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? 16'h0001 : n[CNT_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.rvalid = 1'b0;
    cur_nxt.abort = 1'b0;
    // pin input goes through three flops; level counts when 2 and 3 agree
    cur_nxt.rb_sync = {cur_r.rb_sync[1:0], ready_busy_n};
    if (cur_r.rb_sync[2] == cur_r.rb_sync[1]) begin
      cur_nxt.rb_q = cur_r.rb_sync[2];
    end
    // boost follows request only when idle
    if (cur_r.st == fbmc_pkg::st_idle) begin
      cur_nxt.boost = boost_req;
    end
    if (cur_r.cnt != '0) begin
      cur_nxt.cnt = cur_r.cnt - 16'h0001;
    end
    case (cur_r.st)
      fbmc_pkg::st_reset: begin
        cur_nxt.rst_pin_n = 1'b0;
        cur_nxt.ce_n = 1'b1;
        cur_nxt.oe_n = 1'b1;
        cur_nxt.we_n = 1'b1;
        cur_nxt.doe = 1'b0;
        cur_nxt.boost = 1'b0;
        if (cur_r.cnt == '0) begin
          cur_nxt.rst_pin_n = 1'b1;
          cur_nxt.st = fbmc_pkg::st_recover;
          cur_nxt.cnt = cyc(READY_CYC);
        end
      end
      fbmc_pkg::st_recover: begin
        if (cur_r.cnt <= cyc(READY_CYC) - cyc(`FBMC_RST_HIGH_CYC) &&
            cur_r.rb_q) begin
          cur_nxt.st = fbmc_pkg::st_idle;
          cur_nxt.rdy = 1'b1;
        end else if (cur_r.cnt == '0) begin
          cur_nxt.st = fbmc_pkg::st_idle;
          cur_nxt.rdy = 1'b1;
        end
      end
      fbmc_pkg::st_idle: begin
        if (flash_reset_req) begin
          cur_nxt.rdy = 1'b0;
          cur_nxt.abort = ~cur_r.rb_q;
          cur_nxt.st = fbmc_pkg::st_reset;
          cur_nxt.cnt = cyc(`FBMC_RST_PULSE_CYC);
        end else if (req_valid) begin
          cur_nxt.rdy = 1'b0;
          cur_nxt.op = req_op;
          cur_nxt.addr = req_addr;
          cur_nxt.wdata = req_wdata;
          cur_nxt.ce_n = 1'b0;
          if (req_op == 2'(fbmc_pkg::op_write)) begin
            cur_nxt.oe_n = 1'b1;
            cur_nxt.doe = 1'b1;
            cur_nxt.st = fbmc_pkg::st_wr_setup;
            cur_nxt.cnt = cyc(`FBMC_SETUP_CYC);
          end else begin
            cur_nxt.boost = 1'b0;
            cur_nxt.we_n = 1'b1;
            cur_nxt.oe_n = 1'b0;
            cur_nxt.doe = 1'b0;
            cur_nxt.st = fbmc_pkg::st_rd_wait;
            cur_nxt.cnt = cyc(`FBMC_ACCESS_CYC);
          end
        end
      end
      fbmc_pkg::st_rd_wait: begin
        if (cur_r.cnt == '0) begin
          cur_nxt.rdata = (cur_r.op == 2'(fbmc_pkg::op_id_read)) ?
            (data_pins_i & `FBMC_ID_MASK) : data_pins_i;
          cur_nxt.rvalid = 1'b1;
          cur_nxt.ce_n = 1'b1;
          cur_nxt.oe_n = 1'b1;
          cur_nxt.rdy = 1'b1;
          cur_nxt.st = fbmc_pkg::st_idle;
        end
      end
      fbmc_pkg::st_wr_setup: begin
        if (cur_r.cnt == '0) begin
          cur_nxt.we_n = 1'b0;
          cur_nxt.st = fbmc_pkg::st_wr_low;
          cur_nxt.cnt = cyc(`FBMC_WPULSE_CYC);
        end
      end
      fbmc_pkg::st_wr_low: begin
        if (cur_r.cnt == '0) begin
          cur_nxt.we_n = 1'b1;
          cur_nxt.st = fbmc_pkg::st_wr_high;
          cur_nxt.cnt = cyc(`FBMC_WPULSE_CYC);
        end
      end
      fbmc_pkg::st_wr_high: begin
        if (cur_r.cnt == '0) begin
          cur_nxt.ce_n = 1'b1;
          cur_nxt.doe = 1'b0;
          cur_nxt.rdy = 1'b1;
          cur_nxt.st = fbmc_pkg::st_idle;
        end
      end
      default: begin
        cur_nxt.st = fbmc_pkg::st_reset;
        cur_nxt.cnt = cyc(`FBMC_RST_PULSE_CYC);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '{st: fbmc_pkg::st_reset, cnt: 16'h0019, rb_sync: 3'h7,
                 rb_q: 1'b1, op: 2'h0, addr: '0, wdata: '0, rdata: '0,
                 ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_pin_n: 1'b0,
                 boost: 1'b0, doe: 1'b0, rdy: 1'b0, rvalid: 1'b0,
                 abort: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign req_ready = cur_r.rdy;
  assign rsp_valid = cur_r.rvalid;
  assign rsp_rdata = cur_r.rdata;
  assign aborted = cur_r.abort;
  assign dev_busy = ~cur_r.rb_q;
  assign chip_select_n = cur_r.ce_n;
  assign output_gate_n = cur_r.oe_n;
  assign write_strobe_n = cur_r.we_n;
  assign hw_reset_n = cur_r.rst_pin_n;
  assign program_boost_pin = cur_r.boost;
  assign addr_pins = cur_r.addr;
  assign data_pins_o = cur_r.wdata;
  assign data_pins_oe = cur_r.doe;

  ////////////////////////////////////////////////////////////////////
  // never drive data while the device may drive it
  bus_clash_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(data_pins_oe && !output_gate_n)) else $error("data bus clash");
  read_levels_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !output_gate_n |-> !chip_select_n && write_strobe_n)
    else $error("bad read levels");
  write_levels_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !write_strobe_n |-> !chip_select_n && output_gate_n && data_pins_oe)
    else $error("bad write levels");
  read_time_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(output_gate_n) |-> !output_gate_n [*5])
    else $error("read shorter than access time");
  reset_width_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(hw_reset_n) |-> !hw_reset_n [*8])
    else $error("reset pulse too short");
  reset_quiet_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !hw_reset_n |-> chip_select_n && !program_boost_pin)
    else $error("activity during reset");
  recover_wait_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(hw_reset_n) |-> chip_select_n [*3])
    else $error("access before reset recovery");
  boost_steady_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cur_r.st != fbmc_pkg::st_idle && cur_r.st != fbmc_pkg::st_reset
    |=> $stable(program_boost_pin))
    else $error("boost changed mid cycle");
  // high voltage during a read could damage the part
  boost_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !output_gate_n |-> !program_boost_pin)
    else $error("boost held during read");
endmodule // fbmc_ctrl

/* File: pkg/fbmc_map.svh */
// timing counts and field positions for the flash bus mode controller
`ifndef FBMC_MAP_SVH
`define FBMC_MAP_SVH
`define FBMC_CLK_MHZ 50
`define FBMC_ACCESS_NS 90
`define FBMC_ACCESS_CYC ((`FBMC_ACCESS_NS * `FBMC_CLK_MHZ + 999) / 1000 + 1)
`define FBMC_SETUP_NS 40
`define FBMC_SETUP_CYC ((`FBMC_SETUP_NS * `FBMC_CLK_MHZ + 999) / 1000)
`define FBMC_WPULSE_NS 40
`define FBMC_WPULSE_CYC ((`FBMC_WPULSE_NS * `FBMC_CLK_MHZ + 999) / 1000)
`define FBMC_RST_PULSE_NS 500
`define FBMC_RST_PULSE_CYC ((`FBMC_RST_PULSE_NS * `FBMC_CLK_MHZ + 999) / 1000)
`define FBMC_RST_HIGH_NS 50
`define FBMC_RST_HIGH_CYC ((`FBMC_RST_HIGH_NS * `FBMC_CLK_MHZ + 999) / 1000)
`define FBMC_READY_NS 20000
`define FBMC_READY_CYC ((`FBMC_READY_NS * `FBMC_CLK_MHZ + 999) / 1000)
`define FBMC_ID_MASK 16'h00ff
`define FBMC_SECT_LSB 15
`endif

/* File: pkg/fbmc_pkg.sv */
// types for the flash bus mode controller
package fbmc_pkg;
  typedef enum logic [3:0] {
    st_reset, st_recover, st_idle, st_rd_setup, st_rd_wait,
    st_wr_setup, st_wr_low, st_wr_high
  } fbmc_state_e;
  typedef enum logic [1:0] {
    op_read, op_write, op_id_read
  } fbmc_op_e;
endpackage

/* File: verif/fbmc_flash_model.sv */
// behavioural parallel nor flash answering the controller pins
`timescale 1ns/1ns
module fbmc_flash_model #(
  parameter int BUSY_NS = 400,
  parameter int READY_NS = 1000,
  parameter int ACCESS_NS = 90
) (
  // strobes
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic hw_reset_n,
  // address and data
  input wire logic [21:0] addr_pins,
  input wire logic [15:0] data_pins_o,
  output logic [15:0] data_pins_i,
  // status
  output logic ready_busy_n
);
  logic [15:0] mem [int];
  logic [15:0] last;
  logic drive;
  wire sel_late_n;
  logic [6:0] wr_sect;
  time busy_until;
  initial begin
    busy_until = 0;
    wr_sect = 7'h00;
    last = 16'h0000;
    ready_busy_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // writes taken on strobe rise, never while reset is low
  always @(posedge write_strobe_n) begin
    if (hw_reset_n && !chip_select_n) begin
      mem[int'(addr_pins)] = data_pins_o;
      // each write records the sector named by the top seven bits
      wr_sect = addr_pins[21:15];
      busy_until = $time + BUSY_NS;
    end
  end
  // busy runs on time alone; reset in busy stretches it
  always @(negedge hw_reset_n) begin
    busy_until = ready_busy_n ? $time : $time + READY_NS;
  end
  always #5 ready_busy_n = ($time >= busy_until);
  ////////////////////////////////////////////////////////////////////////////
  // floated bus shows the inverse of the last word
  // data only a full access time after select falls
  assign #(ACCESS_NS) sel_late_n = chip_select_n;
  assign drive = !chip_select_n && !sel_late_n && !output_gate_n &&
                 hw_reset_n;
  // array data with no prior command
  // stable address keeps data latched; new address, new data
  always @* begin
    if (drive) begin
      data_pins_i = mem.exists(int'(addr_pins)) ? mem[int'(addr_pins)]
                    : addr_pins[15:0] ^ 16'h5a5a;
      last = data_pins_i;
    end else begin
      data_pins_i = ~last;
    end
  end
endmodule // fbmc_flash_model

/* File: verif/testbench.sv */
// self-checking bench for the flash bus mode controller
`timescale 1ns/1ns
module testbench;
  typedef struct {logic [1:0] op; logic [21:0] a; logic [15:0] w, e;} fbmc_row_s;
  logic sys_clk, rst_n, req_valid, boost_req, flash_reset_req;
  logic [1:0] req_op;
  logic [21:0] req_addr, addr_pins;
  logic [15:0] req_wdata, rsp_rdata, data_pins_o, data_pins_i, rd;
  logic req_ready, rsp_valid, aborted, dev_busy, chip_select_n;
  logic output_gate_n, write_strobe_n, hw_reset_n, program_boost_pin;
  logic data_pins_oe, ready_busy_n, ab_seen;
  int bad_count, checks;
  fbmc_row_s rows [6] = '{
    '{2'h1, 22'h000123, 16'hbeef, 16'h0}, '{2'h0, 22'h000123, 16'h0, 16'hbeef},
    '{2'h0, 22'h3f8001, 16'h0, 16'hda5b}, '{2'h2, 22'h000001, 16'h0, 16'h005b},
    '{2'h1, 22'h3fffff, 16'h1234, 16'h0}, '{2'h0, 22'h3fffff, 16'h0, 16'h1234}};
  fbmc_ctrl #(.READY_CYC(50)) i_dut (.sys_clk, .rst_n, .req_valid, .req_op,
    .req_addr, .req_wdata, .boost_req, .flash_reset_req, .req_ready,
    .rsp_valid, .rsp_rdata, .aborted, .dev_busy, .chip_select_n,
    .output_gate_n, .write_strobe_n, .hw_reset_n, .program_boost_pin,
    .addr_pins, .data_pins_o, .data_pins_oe, .data_pins_i, .ready_busy_n);
  fbmc_flash_model i_flash (.chip_select_n, .output_gate_n, .write_strobe_n,
    .hw_reset_n, .addr_pins, .data_pins_o, .data_pins_i, .ready_busy_n);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    for (n = 0; n < 300 && req_ready !== 1'b1; n++) @(negedge sys_clk);
    if (n == 300) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic wait_busy(input logic v);
    int n;
    for (n = 0; n < 100 && dev_busy !== v; n++) @(negedge sys_clk);
    if (n == 100) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic issue(input logic [1:0] op, input logic [21:0] a,
                       input logic [15:0] w);
    int n;
    wait_ready();
    req_op = op;
    req_addr = a;
    req_wdata = w;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    for (n = 0; n < 300 && op != 2'h1 && rsp_valid !== 1'b1; n++) begin
      @(negedge sys_clk);
    end
    rd = rsp_rdata;
    if (n == 300) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic pulse_reset();
    wait_ready();
    flash_reset_req = 1'b1;
    @(negedge sys_clk);
    flash_reset_req = 1'b0;
    repeat (2) @(negedge sys_clk);
    wait_ready();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (aborted === 1'b1) ab_seen <= 1'b1;
    // read keeps the write strobe high
    if (rst_n && !chip_select_n && !output_gate_n) check(write_strobe_n, 1);
    if (rst_n && !output_gate_n) check(program_boost_pin, 0);
    // write keeps output gate high and drives the bus
    if (rst_n && !write_strobe_n) check({output_gate_n, data_pins_oe}, 3);
  end
  initial begin
    {rst_n, req_valid, boost_req, flash_reset_req, ab_seen} = 5'h0;
    {req_op, req_addr, req_wdata, bad_count, checks} = '0;
    repeat (8) @(negedge sys_clk);
    check({hw_reset_n, req_ready}, 0);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].a, rows[i].w);
      if (rows[i].op != 2'h1) check(rd, rows[i].e);
    end
    // boost held around a two-cycle program; a read drops it
    boost_req = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(program_boost_pin, 1);
    issue(2'h1, 22'h000555, 16'h00a0);
    issue(2'h1, 22'h008000, 16'h4321);
    issue(2'h0, 22'h008000, 16'h0);
    check(rd, 16'h4321);
    check(i_flash.wr_sect, 16'h0001);
    boost_req = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(program_boost_pin, 0);
    // hw reset while truly idle, then while programming
    wait_busy(1'b0);
    pulse_reset();
    check(ab_seen, 0);
    issue(2'h1, 22'h010000, 16'h5555);
    wait_busy(1'b1);
    check(dev_busy, 1);
    pulse_reset();
    check(ab_seen, 1);
    issue(2'h0, 22'h000123, 16'h0);
    check(rd, 16'hbeef);
    rst_n = 1'b0;
    @(negedge sys_clk);
    check({hw_reset_n, req_ready, data_pins_oe}, 0);
    finish_test();
  end
endmodule // testbench
